/* include/iefl_pkg.sv */
// Package of the interrupt enable and flag logic: register indices, bit positions, reset values.
// Assumes an APB slave with 32-bit data; byte address is four times a register index.
package iefl_pkg;

    localparam int          ADDR_W           = 12;
    localparam int          DATA_W           = 32;
    localparam int          REG_W            = 8;
    localparam int          IDX_W            = 10;
    localparam int          PORTB_W          = 4;
    localparam int          CORE_EVT_W       = 3;
    localparam int          SYNC_STAGES      = 2;

    // Register indices
    localparam logic [9:0]  IDX_MAIN_CTRL_B0 = 10'h00B;
    localparam logic [9:0]  IDX_MAIN_CTRL_B1 = 10'h08B;
    localparam logic [9:0]  IDX_PERIPH_FLAG  = 10'h00C;
    localparam logic [9:0]  IDX_PERIPH_EN    = 10'h08C;
    localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h040;
    localparam logic [9:0]  IDX_IRQ_CLEAR    = 10'h041;
    localparam logic [9:0]  IDX_IRQ_ENABLE   = 10'h042;
    localparam logic [9:0]  IDX_EDGE_CTRL    = 10'h043;

    // Main control bit positions
    localparam int          GLOBAL_EN_BIT    = 7;
    localparam int          PERIPH_EN_BIT    = 6;
    localparam int          TIMER0_COUNT_EN_BIT      = 5;
    localparam int          EXT_EN_BIT       = 4;
    localparam int          PORTB_EN_BIT     = 3;
    localparam int          TIMER0_COUNT_FLAG_BIT    = 2;
    localparam int          EXT_FLAG_BIT     = 1;
    localparam int          PORTB_FLAG_BIT   = 0;

    // Peripheral enable and flag bit positions
    localparam int          ADC_BIT          = 6;
    localparam int          SERIAL_BIT       = 3;
    localparam int          CAPCMP_BIT       = 2;
    localparam int          TMR2_BIT         = 1;
    localparam int          TMR1_BIT         = 0;
    localparam logic [7:0]  PERIPH_IMPL_MASK = 8'h4F;

    // Edge control bit position
    localparam int          EDGE_SEL_BIT     = 0;

    // Reset values
    localparam logic [7:0]  MAIN_CTRL_RST    = 8'h00;
    localparam logic [7:0]  PERIPH_EN_RST    = 8'h00;
    localparam logic [7:0]  PERIPH_FLAG_RST  = 8'h00;
    localparam logic [7:0]  IRQ_STATUS_RST   = 8'h00;
    localparam logic [7:0]  IRQ_ENABLE_RST   = 8'h00;
    localparam logic [7:0]  EDGE_CTRL_RST    = 8'h01;
    localparam logic [31:0] RDATA_RST        = 32'h0000_0000;

endpackage : iefl_pkg

/* src/iefl_pin_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to ref_clk; only the second stage may be read.
`timescale 1ns/1ps
module iefl_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinSync
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= pinIn;
            sync_r <= meta_r;
        end
    end

    assign pinSync = sync_r;

endmodule : iefl_pin_sync

/* src/iefl_edge_detect.sv */
// Edge detector for the external interrupt pin and change detector for the port pins.
// Assumes synchronised inputs; edges count only once the synchroniser holds real pin levels.
`timescale 1ns/1ps
module iefl_edge_detect (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    input  wire logic                          extPin,
    input  wire logic [iefl_pkg::PORTB_W-1:0]  portbPins,
    input  wire logic                          extEdgeSelect,
    output logic                               extEdge,
    output logic                               portbChange
);

    logic [2:0]                   primed_r;
    logic                         extPrev_r;
    logic [iefl_pkg::PORTB_W-1:0] portbPrev_r;
    wire                          extRise = extPin & ~extPrev_r;
    wire                          extFall = ~extPin & extPrev_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            primed_r    <= 3'h0;
            extPrev_r   <= 1'b0;
            portbPrev_r <= '0;
        end else begin
            primed_r    <= {primed_r[1:0], 1'b1};
            extPrev_r   <= extPin;
            portbPrev_r <= portbPins;
        end
    end

    // Edge polarity chosen by the edge select bit
    // History trusted only after the synchroniser has flushed its reset zeros
    assign extEdge     = primed_r[2] & (extEdgeSelect ? extRise : extFall);
    assign portbChange = primed_r[2] & (|(portbPins ^ portbPrev_r));

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_rise_edge_fires: assert property (primed_r[2] && extEdgeSelect && !extPrev_r && extPin
        |-> extEdge) else $error("rising edge missed");
    a_fall_edge_fires: assert property (primed_r[2] && !extEdgeSelect && extPrev_r && !extPin
        |-> extEdge) else $error("falling edge missed");
    a_port_change_fires: assert property (primed_r[2] && $changed(portbPins)
        |-> portbChange) else $error("port change missed");

endmodule : iefl_edge_detect

/* src/iefl_irq_ctrl.sv */
// Interrupt enable and flag logic with APB register access and core request output.
// Assumes event inputs are one-cycle pulses on ref_clk; pins are asynchronous.
//
// How it works
// - Global enable clear blocks coreIrqReq but not irqOut; set lets unmasked sources through.
// - Peripheral group enable gates all peripheral sources onward to coreIrqReq, not to irqOut.
// - A peripheral source never raises coreIrqReq while the group enable is clear.
// - Timer 0 enable bit gates the timer 0 overflow interrupt.
// - An external pin edge sets the external pin flag.
// - Any change on the four upper port pins sets the port change flag.
// - Core and peripheral flags hold until software writes zero; status bits hold until a one is written to the clear register.
// - Flags set whatever the enables say.
// - Main control register answers at two aliased addresses.
// - Peripheral enable register holds five enables at bits 6,3,2,1,0.
// - Unimplemented peripheral enable bits read zero and ignore writes.
// - Peripheral flag register pairs each flag with the same enable position.
// - Main control register resets to zero.
// - Peripheral flags at bits 6,3,2,1,0; other bits read zero.
// - External pin triggers on rising edge when select is one, else falling.
`timescale 1ns/1ps
module iefl_irq_ctrl (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [iefl_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [iefl_pkg::DATA_W-1:0]   pwdata,
    output logic      [iefl_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          extIrqPin,
    input  wire logic [iefl_pkg::PORTB_W-1:0]  portbUpperPins,
    input  wire logic                          timer0Ovf,
    input  wire logic [iefl_pkg::REG_W-1:0]    periphEvt,
    output logic                               coreIrqReq,
    output logic                               irqOut
);

    logic [7:0]  mainCtrl_r;
    logic [7:0]  mainCtrl_nxt;
    logic [7:0]  periphEn_r;
    logic [7:0]  periphEn_nxt;
    logic [7:0]  periphFlag_r;
    logic [7:0]  periphFlag_nxt;
    logic [7:0]  irqStatus_r;
    logic [7:0]  irqStatus_nxt;
    logic [7:0]  irqEnable_r;
    logic [7:0]  edgeCtrl_r;
    logic [31:0] prdata_r;
    logic        coreIrqReq_r;
    logic        irqOut_r;

    logic                         extSync;
    logic [iefl_pkg::PORTB_W-1:0] portbSync;
    logic                         extEdge;
    logic                         portbChange;

    function automatic logic idxHit(input logic [9:0] idx, input logic [9:0] target);
        idxHit = (idx == target);
    endfunction : idxHit

    // Pin synchronisers and edge detection
    iefl_pin_sync #(.W(1)) uExtSync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pinIn   (extIrqPin),
        .pinSync (extSync)
    );

    iefl_pin_sync #(.W(iefl_pkg::PORTB_W)) uPortbSync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pinIn   (portbUpperPins),
        .pinSync (portbSync)
    );

    iefl_edge_detect uEdge (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .extPin        (extSync),
        .portbPins     (portbSync),
        .extEdgeSelect (edgeCtrl_r[iefl_pkg::EDGE_SEL_BIT]),
        .extEdge       (extEdge),
        .portbChange   (portbChange)
    );

    // Address decode
    wire [9:0] regIdx     = paddr[11:2];
    wire       apbSetup   = psel & ~penable;
    wire       apbWrite   = psel & penable & pwrite;
    wire [7:0] wrByte     = pwdata[7:0];
    wire       hitMain    = idxHit(regIdx, iefl_pkg::IDX_MAIN_CTRL_B0)
                          | idxHit(regIdx, iefl_pkg::IDX_MAIN_CTRL_B1);
    wire       hitPEn     = idxHit(regIdx, iefl_pkg::IDX_PERIPH_EN);
    wire       hitPFlag   = idxHit(regIdx, iefl_pkg::IDX_PERIPH_FLAG);
    wire       hitStatus  = idxHit(regIdx, iefl_pkg::IDX_IRQ_STATUS);
    wire       hitClear   = idxHit(regIdx, iefl_pkg::IDX_IRQ_CLEAR);
    wire       hitIrqEn   = idxHit(regIdx, iefl_pkg::IDX_IRQ_ENABLE);
    wire       hitEdge    = idxHit(regIdx, iefl_pkg::IDX_EDGE_CTRL);
    wire       hitAny     = hitMain | hitPEn | hitPFlag | hitStatus | hitClear
                          | hitIrqEn | hitEdge;
    wire       wrMain     = apbWrite & hitMain;
    wire       wrPEn      = apbWrite & hitPEn;
    wire       wrPFlag    = apbWrite & hitPFlag;
    wire       wrClear    = apbWrite & hitClear;
    wire       wrIrqEn    = apbWrite & hitIrqEn;
    wire       wrEdge     = apbWrite & hitEdge;

    // Event vectors
    wire [2:0] coreEvt    = {timer0Ovf, extEdge, portbChange};
    wire [7:0] periphImp  = periphEvt & iefl_pkg::PERIPH_IMPL_MASK;
    wire [7:0] allEvt     = {periphImp[iefl_pkg::ADC_BIT], periphImp[3:0], coreEvt};

    // Register next values; events win over a same-cycle clear
    wire [7:0] mainBase   = wrMain ? wrByte : mainCtrl_r;
    assign mainCtrl_nxt   = mainBase | {5'h00, coreEvt};
    wire [7:0] pEnBase    = wrPEn ? wrByte : periphEn_r;
    assign periphEn_nxt   = pEnBase & iefl_pkg::PERIPH_IMPL_MASK;
    wire [7:0] pFlagBase  = wrPFlag ? wrByte : periphFlag_r;
    assign periphFlag_nxt = (pFlagBase | periphImp) & iefl_pkg::PERIPH_IMPL_MASK;
    wire [7:0] clrMask    = wrClear ? wrByte : 8'h00;
    assign irqStatus_nxt  = (irqStatus_r & ~clrMask) | allEvt;

    // Request combination
    wire [2:0] coreEnBits = mainCtrl_r[iefl_pkg::TIMER0_COUNT_EN_BIT:iefl_pkg::PORTB_EN_BIT];
    wire [2:0] coreFlags  = mainCtrl_r[iefl_pkg::TIMER0_COUNT_FLAG_BIT:iefl_pkg::PORTB_FLAG_BIT];
    wire       coreGrp    = |(coreEnBits & coreFlags);
    wire       periphGrp  = mainCtrl_r[iefl_pkg::PERIPH_EN_BIT]
                          & (|(periphEn_r & periphFlag_r));
    wire       reqNxt     = mainCtrl_r[iefl_pkg::GLOBAL_EN_BIT] & (coreGrp | periphGrp);

    // Read mux
    wire [7:0] rdByte     = hitMain   ? mainCtrl_r   :
                            hitPEn    ? periphEn_r   :
                            hitPFlag  ? periphFlag_r :
                            hitStatus ? irqStatus_r  :
                            hitIrqEn  ? irqEnable_r  :
                            hitEdge   ? edgeCtrl_r   : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mainCtrl_r   <= iefl_pkg::MAIN_CTRL_RST;
            periphEn_r   <= iefl_pkg::PERIPH_EN_RST;
            periphFlag_r <= iefl_pkg::PERIPH_FLAG_RST;
            irqStatus_r  <= iefl_pkg::IRQ_STATUS_RST;
        end else begin
            mainCtrl_r   <= mainCtrl_nxt;
            periphEn_r   <= periphEn_nxt;
            periphFlag_r <= periphFlag_nxt;
            irqStatus_r  <= irqStatus_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irqEnable_r <= iefl_pkg::IRQ_ENABLE_RST;
            edgeCtrl_r  <= iefl_pkg::EDGE_CTRL_RST;
        end else begin
            if (wrIrqEn) begin
                irqEnable_r <= wrByte;
            end
            if (wrEdge) begin
                edgeCtrl_r <= {7'h00, wrByte[iefl_pkg::EDGE_SEL_BIT]};
            end
        end
    end

    // Read data captured in the setup cycle, clear register reads zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata_r <= iefl_pkg::RDATA_RST;
        end else if (apbSetup) begin
            prdata_r <= {24'h00_0000, (hitClear ? 8'h00 : rdByte)};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            coreIrqReq_r <= 1'b0;
            irqOut_r     <= 1'b0;
        end else begin
            coreIrqReq_r <= reqNxt;
            irqOut_r     <= |(irqStatus_r & irqEnable_r);
        end
    end

    assign prdata     = prdata_r;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~hitAny;
    assign coreIrqReq = coreIrqReq_r;
    assign irqOut     = irqOut_r;

    property p_reset_clears;
        // Checked through reset, so the reset disable must not apply here
        @(posedge ref_clk) disable iff (1'b0) !rst_n |=> (mainCtrl_r == 8'h00);
    endproperty

    a_reset_main_zero: assert property (p_reset_clears)
        else $error("main control not zero after reset");

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_global_blocks_req: assert property (!mainCtrl_r[7] |=> !coreIrqReq)
        else $error("request while global enable clear");
    a_global_passes_core: assert property (mainCtrl_r[7] && coreGrp |=> coreIrqReq)
        else $error("enabled core flag gave no request");
    a_periph_group_blocks: assert property (!mainCtrl_r[6] && !coreGrp |=> !coreIrqReq)
        else $error("peripheral request with group enable clear");
    a_periph_passes: assert property (mainCtrl_r[7] && periphGrp |=> coreIrqReq)
        else $error("enabled peripheral flag gave no request");
    a_timer0_count_gate_on: assert property (mainCtrl_r[7] && mainCtrl_r[5] && timer0Ovf && !wrMain
        |=> mainCtrl_r[2] ##1 coreIrqReq)
        else $error("timer 0 interrupt not raised");
    a_timer0_count_gate_off: assert property (!mainCtrl_r[5] && !mainCtrl_r[4] && !mainCtrl_r[3]
        && !periphGrp |=> !coreIrqReq)
        else $error("request with core enables clear");
    a_ext_flag_set: assert property (extEdge |=> mainCtrl_r[1])
        else $error("external flag not set");
    a_port_flag_set: assert property (portbChange |=> mainCtrl_r[0])
        else $error("port change flag not set");
    a_flag_sticky: assert property (mainCtrl_r[2] && !wrMain |=> mainCtrl_r[2])
        else $error("flag dropped without write");
    a_flag_set_wins: assert property (wrMain && !wrByte[1] && extEdge |=> mainCtrl_r[1])
        else $error("event lost against clear");
    a_alias_same_store: assert property (apbWrite && idxHit(regIdx, iefl_pkg::IDX_MAIN_CTRL_B1)
        && coreEvt == 3'h0 |=> mainCtrl_r == $past(wrByte))
        else $error("alias write missed storage");
    a_unimpl_en_zero: assert property ((periphEn_r & ~iefl_pkg::PERIPH_IMPL_MASK) == 8'h00)
        else $error("unimplemented enable bit set");
    a_periph_flag_pair: assert property (periphEvt[6] |=> periphFlag_r[6])
        else $error("peripheral flag not set");
    a_unimpl_flag_zero: assert property ((periphFlag_r & ~iefl_pkg::PERIPH_IMPL_MASK) == 8'h00)
        else $error("unimplemented flag bit set");

    c_core_req: cover property ($rose(coreIrqReq) && coreGrp);
    c_periph_req: cover property (periphGrp && mainCtrl_r[7] ##1 coreIrqReq);
    c_alias_write: cover property (wrMain && idxHit(regIdx, iefl_pkg::IDX_MAIN_CTRL_B1));
    c_irq_out: cover property ($rose(irqOut));

endmodule : iefl_irq_ctrl

/* sim/iefl_src_model.sv */
// Model of the event sources facing the interrupt logic: timer and peripheral pulses, pins.
// Assumes the bench calls its tasks; every output changes just after a rising ref_clk edge.
`timescale 1ns/1ps
module iefl_src_model (
    input  wire logic                         ref_clk,
    output logic                              timer0Ovf,
    output logic [iefl_pkg::REG_W-1:0]        periphEvt,
    output logic                              extIrqPin,
    output logic [iefl_pkg::PORTB_W-1:0]      portbUpperPins
);
    initial begin
        timer0Ovf = 1'b0;
        periphEvt = 8'h00;
        extIrqPin = 1'b0;
        portbUpperPins = 4'h0;
    end

    // One-cycle event pulse, as a timer or peripheral would give it
    task automatic pulse(input logic t0, input logic [7:0] pev);
        @(posedge ref_clk);
        timer0Ovf <= t0;
        periphEvt <= pev;
        @(posedge ref_clk);
        timer0Ovf <= 1'b0;
        periphEvt <= 8'h00;
    endtask : pulse

    // New levels on the external pin and the upper port pins
    task automatic pins(input logic ext, input logic [3:0] pb);
        @(posedge ref_clk);
        extIrqPin <= ext;
        portbUpperPins <= pb;
    endtask : pins
endmodule : iefl_src_model

/* sim/test_interrupt_enable_flag_logic.sv */
// Self-checking bench of the interrupt enable and flag logic over APB.
// Assumes iefl_pkg, iefl_irq_ctrl and the source model are compiled before it.
`timescale 1ns/1ps
module test_interrupt_enable_flag_logic;
    localparam logic [11:0] A_MAIN  = 12'h02C;
    localparam logic [11:0] A_ALIAS = 12'h22C;
    localparam logic [11:0] A_PFLAG = 12'h030;
    localparam logic [11:0] A_PEN   = 12'h230;
    localparam logic [11:0] A_STAT  = 12'h100;
    localparam logic [11:0] A_CLR   = 12'h104;
    localparam logic [11:0] A_IEN   = 12'h108;
    localparam logic [11:0] A_EDGE  = 12'h10C;
    localparam logic [11:0] A_BAD   = 12'h3FC;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         timer0Ovf;
    wire  [7:0]  periphEvt;
    wire         extIrqPin;
    wire  [3:0]  portbUpperPins;
    wire         coreIrqReq;
    wire         irqOut;
    int          mismatches = 0;
    int          checkCount = 0;
    int          bits [5] = '{6, 3, 2, 1, 0};

    always #2.5 ref_clk = ~ref_clk;

    iefl_irq_ctrl u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extIrqPin(extIrqPin), .portbUpperPins(portbUpperPins), .timer0Ovf(timer0Ovf),
        .periphEvt(periphEvt), .coreIrqReq(coreIrqReq), .irqOut(irqOut)
    );

    iefl_src_model u_src (
        .ref_clk(ref_clk), .timer0Ovf(timer0Ovf), .periphEvt(periphEvt),
        .extIrqPin(extIrqPin), .portbUpperPins(portbUpperPins)
    );

    task automatic endSim();
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : endSim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer: setup, then access until pready is seen high
    task automatic apb(input logic [11:0] addr, input logic wr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        logic [31:0] d;
        logic        e;
        apb(addr, 1'b1, data, d, e);
    endtask : wr

    task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input string name);
        logic [31:0] d;
        logic        e;
        apb(addr, 1'b0, 32'h0000_0000, d, e);
        chk(name, exp, d);
        chk("pslverr", 32'h0000_0000, {31'h0, e});
    endtask : rd

    // Output levels settle one edge after the register change; checked after two
    task automatic outChk(input logic expReq, input logic expIrq);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("coreIrqReq", {31'h0, expReq}, {31'h0, coreIrqReq});
        chk("irqOut", {31'h0, expIrq}, {31'h0, irqOut});
    endtask : outChk

    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        $display("watchdog expired");
        endSim();
    end

    initial begin
        logic [31:0] d;
        logic        e;
        logic [7:0]  m;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(A_MAIN, 32'h0000_0000, "main reset");
        rd(A_PEN, 32'h0000_0000, "enables reset");
        rd(A_PFLAG, 32'h0000_0000, "flags reset");
        rd(A_STAT, 32'h0000_0000, "status reset");
        rd(A_EDGE, 32'h0000_0001, "edge reset");
        outChk(1'b0, 1'b0);
        $display("test reset done");
        wr(A_MAIN, 32'h0000_0038);
        rd(A_ALIAS, 32'h0000_0038, "alias read");
        wr(A_ALIAS, 32'h0000_0000);
        rd(A_MAIN, 32'h0000_0000, "alias write");
        wr(A_PEN, 32'h0000_00FF);
        rd(A_PEN, 32'h0000_004F, "enables mask");
        wr(A_PFLAG, 32'h0000_00FF);
        rd(A_PFLAG, 32'h0000_004F, "flags mask");
        wr(A_PFLAG, 32'h0000_0000);
        wr(A_PEN, 32'h0000_0000);
        apb(A_BAD, 1'b0, 32'h0000_0000, d, e);
        chk("unmapped error", 32'h0000_0001, {31'h0, e});
        chk("unmapped data", 32'h0000_0000, d);
        $display("test registers done");
        u_src.pulse(1'b1, 8'h00);
        repeat (6) @(posedge ref_clk);
        rd(A_MAIN, 32'h0000_0004, "timer0 flag");
        wr(A_MAIN, 32'h0000_0024);
        outChk(1'b0, 1'b0);
        wr(A_MAIN, 32'h0000_00A4);
        outChk(1'b1, 1'b0);
        wr(A_MAIN, 32'h0000_0084);
        outChk(1'b0, 1'b0);
        wr(A_MAIN, 32'h0000_00A0);
        rd(A_MAIN, 32'h0000_00A0, "timer0 cleared");
        outChk(1'b0, 1'b0);
        $display("test timer0 done");
        foreach (bits[i]) begin
            m = 8'h01 << bits[i];
            wr(A_PFLAG, 32'h0000_0000);
            wr(A_PEN, {24'h0, m});
            wr(A_MAIN, 32'h0000_0080);
            u_src.pulse(1'b0, m);
            rd(A_PFLAG, {24'h0, m}, "periph flag");
            outChk(1'b0, 1'b0);
            wr(A_MAIN, 32'h0000_00C0);
            outChk(1'b1, 1'b0);
            wr(A_MAIN, 32'h0000_0040);
            outChk(1'b0, 1'b0);
            wr(A_PFLAG, 32'h0000_0000);
            wr(A_MAIN, 32'h0000_0000);
        end
        u_src.pulse(1'b0, 8'hB0);
        rd(A_PFLAG, 32'h0000_0000, "unused events");
        $display("test peripheral done");
        u_src.pins(1'b1, 4'h0);
        repeat (8) @(posedge ref_clk);
        rd(A_MAIN, 32'h0000_0002, "rising edge");
        wr(A_MAIN, 32'h0000_0000);
        u_src.pins(1'b0, 4'h0);
        repeat (8) @(posedge ref_clk);
        rd(A_MAIN, 32'h0000_0000, "falling ignored");
        wr(A_EDGE, 32'h0000_0000);
        u_src.pins(1'b1, 4'h0);
        repeat (8) @(posedge ref_clk);
        rd(A_MAIN, 32'h0000_0000, "rising ignored");
        u_src.pins(1'b0, 4'h0);
        repeat (8) @(posedge ref_clk);
        rd(A_MAIN, 32'h0000_0002, "falling edge");
        wr(A_MAIN, 32'h0000_0082);
        outChk(1'b0, 1'b0);
        wr(A_MAIN, 32'h0000_0092);
        outChk(1'b1, 1'b0);
        wr(A_MAIN, 32'h0000_0000);
        u_src.pins(1'b0, 4'h8);
        repeat (8) @(posedge ref_clk);
        rd(A_MAIN, 32'h0000_0001, "port change");
        wr(A_MAIN, 32'h0000_0081);
        outChk(1'b0, 1'b0);
        wr(A_MAIN, 32'h0000_0089);
        outChk(1'b1, 1'b0);
        wr(A_MAIN, 32'h0000_0000);
        repeat (8) @(posedge ref_clk);
        rd(A_MAIN, 32'h0000_0000, "port still");
        $display("test pins done");
        wr(A_STAT, 32'h0000_0000);
        rd(A_STAT, 32'h0000_00FF, "status all");
        outChk(1'b0, 1'b0);
        wr(A_IEN, 32'h0000_0004);
        outChk(1'b0, 1'b1);
        wr(A_IEN, 32'h0000_0000);
        outChk(1'b0, 1'b0);
        wr(A_IEN, 32'h0000_0004);
        wr(A_CLR, 32'h0000_00FF);
        rd(A_STAT, 32'h0000_0000, "status clear");
        rd(A_CLR, 32'h0000_0000, "clear reads");
        outChk(1'b0, 1'b0);
        $display("test status done");
        endSim();
    end
endmodule : test_interrupt_enable_flag_logic
